//--- shared/prmc_pkg.sv
// Package for the power reduction mode controller.
// Assumes a single core clock; no software-visible registers.
package prmc_pkg;
	// Low-power request codes from the instruction decoder
	localparam logic [1:0] REQ_NONE = 2'h0;
	localparam logic [1:0] REQ_IDLE = 2'h1;
	localparam logic [1:0] REQ_PDOWN = 2'h2;
	// Ready handshake polarity: 0 active low, 1 active high
	localparam logic READY_POL_LOW = 1'h0;
	// Default number of fast external interrupt pins
	localparam int FAST_IRQ_NUM = 4;
	// Synchroniser depth for pin inputs
	localparam int SYNC_DEPTH = 3;
	// Reset values
	localparam logic CLK_ON_RST = 1'h1;
	localparam logic READY_SEEN_RST = 1'h1;
	localparam logic FLAG_RST = 1'h0;
	typedef enum logic [2:0] {
		PR_RUN,
		PR_DRAIN,
		PR_IDLE,
		PR_PDOWN,
		PR_WAKE
	} prmc_state_t;
endpackage

//--- core/prmc_pin_sync.sv
// Three-stage synchroniser bank for asynchronous pin inputs.
// Assumes the pins are quasi-static compared to the core clock.
`timescale 1ns/10ps
module prmc_pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinLevel
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] mid_r;
	logic [WIDTH-1:0] last_r;
	logic [WIDTH-1:0] level_r;
	genvar i;
	// A zero-width bank has no bits to carry
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be at least 1");
	end
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// A change counts only once stages two and three agree
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					meta_r[i] <= 1'h0;
					mid_r[i] <= 1'h0;
					last_r[i] <= 1'h0;
					level_r[i] <= 1'h0;
				end else begin
					meta_r[i] <= pinIn[i];
					mid_r[i] <= meta_r[i];
					last_r[i] <= mid_r[i];
					if (mid_r[i] == last_r[i]) begin
						level_r[i] <= last_r[i];
					end
				end
			end
		end
	endgenerate
	assign pinLevel = level_r;
endmodule // prmc_pin_sync

//--- core/prmc_ctrl.sv
// Power reduction mode controller: gates core and peripheral clocks.
// Assumes the core raises a one-cycle request and the bus unit reports
// activity and sampled ready levels on this same clock.
`timescale 1ns/10ps
module prmc_ctrl #(
	parameter int FAST_NUM = prmc_pkg::FAST_IRQ_NUM
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] pwrReq,
	input wire logic busActive,
	input wire logic busAccessEnd,
	input wire logic readyEnable,
	input wire logic readyPolarity,
	input wire logic readyLevel,
	input wire logic irqPending,
	input wire logic pdFastOnly,
	input wire logic [FAST_NUM-1:0] fastIrqPin,
	output logic coreClkEn,
	output logic periClkEn,
	output logic idleActive,
	output logic pdownActive,
	output logic entryRefused,
	output logic wakePulse
);
	// The sync bank and the wake OR are only sized for this range
	if (FAST_NUM < 1 || FAST_NUM > 16) begin : g_bad_fast_num
		$error("FAST_NUM must be 1 to 16");
	end

	prmc_pkg::prmc_state_t state_r, state_nxt;
	logic [1:0] target_r;
	logic readySeen_r;
	logic coreClkEn_r, periClkEn_r, idle_r, pdown_r, refused_r, wake_r;
	logic [FAST_NUM-1:0] fastLevel;

	prmc_pin_sync #(.WIDTH(FAST_NUM)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pinIn(fastIrqPin),
		.pinLevel(fastLevel)
	);

	wire readyActive = (readyPolarity == prmc_pkg::READY_POL_LOW) ?
		!readyLevel : readyLevel;
	// Verdict of the last finished access; one ending now counts next cycle
	wire readyOk = !readyEnable || readySeen_r;
	wire newReq = (pwrReq == prmc_pkg::REQ_IDLE) ||
		(pwrReq == prmc_pkg::REQ_PDOWN);
	wire fastHit = |fastLevel;
	// Fast-only mode ignores ordinary interrupts in power down
	wire pdWake = pdFastOnly ? fastHit : (fastHit || irqPending);
	wire idleWake = irqPending;
	wire drainDone = !busActive;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			readySeen_r <= prmc_pkg::READY_SEEN_RST;
		end else if (busAccessEnd) begin
			readySeen_r <= readyActive;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			prmc_pkg::PR_RUN: begin
				if (newReq) begin
					state_nxt = prmc_pkg::PR_DRAIN;
				end
			end
			prmc_pkg::PR_DRAIN: begin
				if (drainDone && !readyOk) begin
					state_nxt = prmc_pkg::PR_RUN;
				end else if (drainDone) begin
					state_nxt = (target_r == prmc_pkg::REQ_PDOWN) ?
						prmc_pkg::PR_PDOWN : prmc_pkg::PR_IDLE;
				end
			end
			prmc_pkg::PR_IDLE: begin
				if (idleWake) begin
					state_nxt = prmc_pkg::PR_WAKE;
				end
			end
			prmc_pkg::PR_PDOWN: begin
				if (pdWake) begin
					state_nxt = prmc_pkg::PR_WAKE;
				end
			end
			prmc_pkg::PR_WAKE: state_nxt = prmc_pkg::PR_RUN;
			default: state_nxt = prmc_pkg::PR_RUN;
		endcase
	end

	// Clock enables decoded from the next state so outputs stay registered
	wire nxtIdle = (state_nxt == prmc_pkg::PR_IDLE);
	wire nxtPdown = (state_nxt == prmc_pkg::PR_PDOWN);
	wire coreEnNxt = !(nxtIdle || nxtPdown);
	wire periEnNxt = !nxtPdown;
	wire refuseNxt = (state_r == prmc_pkg::PR_DRAIN) && drainDone &&
		!readyOk;
	wire wakeNxt = (state_r == prmc_pkg::PR_WAKE);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r <= prmc_pkg::PR_RUN;
			target_r <= prmc_pkg::REQ_NONE;
			coreClkEn_r <= prmc_pkg::CLK_ON_RST;
			periClkEn_r <= prmc_pkg::CLK_ON_RST;
			idle_r <= prmc_pkg::FLAG_RST;
			pdown_r <= prmc_pkg::FLAG_RST;
			refused_r <= prmc_pkg::FLAG_RST;
			wake_r <= prmc_pkg::FLAG_RST;
		end else begin
			state_r <= state_nxt;
			if (state_r == prmc_pkg::PR_RUN && newReq) begin
				target_r <= pwrReq;
			end
			coreClkEn_r <= coreEnNxt;
			periClkEn_r <= periEnNxt;
			idle_r <= nxtIdle;
			pdown_r <= nxtPdown;
			refused_r <= refuseNxt;
			wake_r <= wakeNxt;
		end
	end

	assign coreClkEn = coreClkEn_r;
	assign periClkEn = periClkEn_r;
	assign idleActive = idle_r;
	assign pdownActive = pdown_r;
	assign entryRefused = refused_r;
	assign wakePulse = wake_r;

	// Antecedents that reach past one edge also sample rst_n: a reset
	// released on the very edge it is applied escapes disable iff
	idle_clocks_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		idleActive |-> !coreClkEn && periClkEn)
		else $error("idle clock enables wrong");
	pdown_clocks_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		pdownActive |-> !coreClkEn && !periClkEn)
		else $error("power down clock enables wrong");
	two_states_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		!(idleActive && pdownActive))
		else $error("both low-power states at once");
	idle_wake_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && state_r == prmc_pkg::PR_IDLE && irqPending)
		|=> ##1 wakePulse && coreClkEn)
		else $error("idle did not wake on interrupt");
	pd_fastonly_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && state_r == prmc_pkg::PR_PDOWN && pdFastOnly
		&& !fastHit) |=> state_r == prmc_pkg::PR_PDOWN)
		else $error("power down left without fast pin");
	bus_drain_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(busActive && state_r == prmc_pkg::PR_DRAIN)
		|=> !idleActive && !pdownActive)
		else $error("low-power entered during bus activity");
	ready_refuse_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && state_r == prmc_pkg::PR_DRAIN && !busActive
		&& readyEnable && !readySeen_r) |=> entryRefused && coreClkEn)
		else $error("entry not refused without ready");
	wake_resume_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(wakePulse) |-> coreClkEn && periClkEn ##1 !wakePulse)
		else $error("wake did not restart core");
	ready_accept_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && state_r == prmc_pkg::PR_DRAIN && !busActive
		&& readyOk) |=> (idleActive || pdownActive) && !entryRefused)
		else $error("entry refused although ready was seen");
	refuse_pulse_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		entryRefused |=> !entryRefused)
		else $error("refusal flag held longer than one cycle");
	refuse_stays_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		entryRefused |-> !idleActive && !pdownActive && coreClkEn
		&& periClkEn)
		else $error("refused entry still gated a clock");
	entry_guard_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		($rose(idleActive) || $rose(pdownActive))
		|-> $past(state_r) == prmc_pkg::PR_DRAIN && !$past(busActive)
		&& (!$past(readyEnable) || $past(readySeen_r)))
		else $error("low-power state entered without a clean drain");
	idle_kind_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(idleActive) |-> $past(target_r) == prmc_pkg::REQ_IDLE)
		else $error("idle entered for a power down request");
	pd_kind_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(pdownActive)
		|-> $past(target_r) == prmc_pkg::REQ_PDOWN)
		else $error("power down entered for an idle request");
	core_gate_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		!coreClkEn |-> idleActive || pdownActive)
		else $error("core clock stopped outside a low-power state");
	peri_gate_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		!periClkEn |-> pdownActive)
		else $error("peripheral clock stopped outside power down");
	idle_holds_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && state_r == prmc_pkg::PR_IDLE && !irqPending)
		|=> idleActive && !coreClkEn)
		else $error("idle left without interrupt or reset");
	pd_irq_wake_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && state_r == prmc_pkg::PR_PDOWN && !pdFastOnly
		&& irqPending) |=> !pdownActive && coreClkEn && periClkEn)
		else $error("power down ignored an interrupt");
	pd_fast_wake_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && state_r == prmc_pkg::PR_PDOWN && fastHit)
		|=> ##1 wakePulse && coreClkEn && periClkEn)
		else $error("fast pin did not end power down");
	drain_exit_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(state_r == prmc_pkg::PR_DRAIN && !busActive)
		|=> state_r != prmc_pkg::PR_DRAIN)
		else $error("drain did not end once the bus was idle");
endmodule // prmc_ctrl

//--- sim/prmc_ctrl_tb.sv
// Self-checking bench for the power reduction mode controller.
// Assumes prmc_pkg and both core modules are compiled first.
`timescale 1ns/10ps
module prmc_ctrl_tb;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [1:0] pwrReq = prmc_pkg::REQ_NONE;
	logic busActive = 1'h0, busAccessEnd = 1'h0, irqPending = 1'h0;
	logic readyEnable = 1'h0, readyPolarity = 1'h0, readyLevel = 1'h0;
	logic pdFastOnly = 1'h0;
	logic [3:0] fastIrqPin = 4'h0;
	logic coreClkEn, periClkEn, idleActive, pdownActive;
	logic entryRefused, wakePulse;
	int miscompares = 0;
	int checks_done = 0;

	prmc_ctrl #(.FAST_NUM(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.pwrReq(pwrReq), .busActive(busActive), .busAccessEnd(busAccessEnd),
		.readyEnable(readyEnable), .readyPolarity(readyPolarity),
		.readyLevel(readyLevel), .irqPending(irqPending),
		.pdFastOnly(pdFastOnly), .fastIrqPin(fastIrqPin),
		.coreClkEn(coreClkEn), .periClkEn(periClkEn),
		.idleActive(idleActive), .pdownActive(pdownActive),
		.entryRefused(entryRefused), .wakePulse(wakePulse));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task chk(input logic got, input logic exp, input string m);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	// Verdict kept by the block: ready disabled or seen at its active level
	function logic ready_ok(input logic en, input logic pol, input logic lvl);
		return !en || (lvl == pol);
	endfunction

	task access(input logic en, input logic pol, input logic lvl);
		@(posedge ref_clk);
		readyEnable <= en;
		readyPolarity <= pol;
		readyLevel <= lvl;
		busAccessEnd <= 1'h1;
		@(posedge ref_clk);
		busAccessEnd <= 1'h0;
	endtask

	task req(input logic [1:0] c);
		@(posedge ref_clk);
		pwrReq <= c;
		@(posedge ref_clk);
		pwrReq <= prmc_pkg::REQ_NONE;
	endtask

	task try(input logic [1:0] c, input logic ok);
		logic pd;
		pd = ok && c == prmc_pkg::REQ_PDOWN;
		req(c);
		@(negedge ref_clk);
		@(negedge ref_clk);
		chk(entryRefused, !ok, "refusal flag");
		chk(idleActive, ok && !pd, "idle state");
		chk(pdownActive, pd, "power down state");
		chk(coreClkEn, !ok, "core clock");
		chk(periClkEn, !pd, "peripheral clock");
	endtask

	task wake_irq;
		@(posedge ref_clk);
		irqPending <= 1'h1;
		@(posedge ref_clk);
		irqPending <= 1'h0;
		@(negedge ref_clk);
		chk(idleActive | pdownActive, 1'h0, "still asleep");
		chk(coreClkEn & periClkEn, 1'h1, "clocks not back");
		@(negedge ref_clk);
		chk(wakePulse, 1'h1, "no wake pulse");
		@(negedge ref_clk);
		chk(wakePulse, 1'h0, "wake pulse too long");
	endtask

	initial begin
		#200000;
		miscompares++;
		$display("mismatch at %0t: timeout", $time);
		report_and_stop;
	end

	initial begin
		logic en, pol, lvl;
		logic [1:0] c;
		int n;
		void'($urandom(32'hff71f46f));
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(negedge ref_clk);
		chk(coreClkEn & periClkEn & !idleActive, 1'h1, "reset state");
		// A pending transfer holds the controller in drain
		@(posedge ref_clk);
		busActive <= 1'h1;
		req(prmc_pkg::REQ_IDLE);
		n = $urandom_range(8, 1);
		repeat (n) begin
			@(negedge ref_clk);
			chk(idleActive, 1'h0, "entered with bus busy");
		end
		@(posedge ref_clk);
		busActive <= 1'h0;
		@(negedge ref_clk);
		@(negedge ref_clk);
		chk(idleActive & periClkEn & !coreClkEn, 1'h1, "idle entry");
		wake_irq;
		access(1'h1, 1'h0, 1'h1);
		try(prmc_pkg::REQ_IDLE, 1'h0);
		// Code 3 is no request: with ready unseen it would show a refusal
		req(2'h3);
		@(negedge ref_clk);
		@(negedge ref_clk);
		chk(entryRefused | idleActive, 1'h0, "code 3 taken");
		for (int i = 0; i < 14; i++) begin
			en = 1'($urandom);
			pol = 1'($urandom);
			lvl = 1'($urandom);
			c = ($urandom & 1) ? prmc_pkg::REQ_PDOWN : prmc_pkg::REQ_IDLE;
			access(en, pol, lvl);
			try(c, ready_ok(en, pol, lvl));
			if (ready_ok(en, pol, lvl)) begin
				wake_irq;
			end
		end
		// Fast-only power down ignores ordinary interrupts
		@(posedge ref_clk);
		pdFastOnly <= 1'h1;
		access(1'h0, 1'h0, 1'h0);
		try(prmc_pkg::REQ_PDOWN, 1'h1);
		@(posedge ref_clk);
		irqPending <= 1'h1;
		repeat (6) @(negedge ref_clk);
		chk(pdownActive, 1'h1, "woke on ordinary irq");
		@(posedge ref_clk);
		irqPending <= 1'h0;
		fastIrqPin <= 4'h1 << $urandom_range(3, 0);
		n = 0;
		while (pdownActive === 1'h1 && n < 12) begin
			@(negedge ref_clk);
			n++;
		end
		chk(pdownActive === 1'h0 && coreClkEn, 1'h1, "fast pin wake");
		@(posedge ref_clk);
		fastIrqPin <= 4'h0;
		pdFastOnly <= 1'h0;
		repeat (6) @(posedge ref_clk);
		// Without fast-only, a fast pin still ends power down
		try(prmc_pkg::REQ_PDOWN, 1'h1);
		@(posedge ref_clk);
		fastIrqPin <= 4'h1 << $urandom_range(3, 0);
		repeat (6) @(negedge ref_clk);
		chk(!pdownActive & coreClkEn, 1'h1, "fast wake, mixed");
		@(posedge ref_clk);
		fastIrqPin <= 4'h0;
		repeat (6) @(posedge ref_clk);
		try(prmc_pkg::REQ_IDLE, 1'h1);
		@(posedge ref_clk);
		rst_n <= 1'h0;
		@(posedge ref_clk);
		rst_n <= 1'h1;
		@(negedge ref_clk);
		chk(!idleActive && coreClkEn, 1'h1, "reset left idle");
		report_and_stop;
	end
endmodule // prmc_ctrl_tb
